// ### hdl/iack_pkg.sv
// package: constants and types shared by both ends of the interrupt acknowledge link
package iack_pkg;
    localparam int unsigned VEC_W          = 8;
    localparam int unsigned LVL_W          = 3;
    localparam logic [7:0]  VEC_SPURIOUS   = 8'h18;
    localparam logic [7:0]  VEC_AUTO_BASE  = 8'h18;
    localparam int unsigned TIMEOUT_NS     = 80;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned TIMEOUT_CYC    = TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned TMO_W          = 4;

    typedef enum logic [1:0] {
        IACK_TERM_VECTOR   = 2'b00,
        IACK_TERM_AUTO     = 2'b01,
        IACK_TERM_SPURIOUS = 2'b10
    } iack_term_t;

    typedef enum logic [2:0] {
        IACK_CPU_IDLE   = 3'b000,
        IACK_CPU_ACK    = 3'b001,
        IACK_CPU_DONE   = 3'b010,
        IACK_CPU_HNDLR  = 3'b011,
        IACK_CPU_RETRY  = 3'b100
    } iack_cpu_state_t;
endpackage : iack_pkg

// ### hdl/iack_if.sv
// interface: interrupt acknowledge bus between processor and interrupt logic
`timescale 1ns/100ps
interface iack_if;
    logic       iack_start;
    logic       iack_busy;
    logic [2:0] iack_level;
    logic       transfer_acknowledge_n;
    logic       transfer_error_acknowledge_n;
    logic       autovector_request_n;
    logic [7:0] data;

    modport cpu (
        output iack_start, iack_busy, iack_level,
        input  transfer_acknowledge_n, transfer_error_acknowledge_n, autovector_request_n, data
    );
    modport src (
        input  iack_start, iack_busy, iack_level,
        output transfer_acknowledge_n, transfer_error_acknowledge_n, autovector_request_n, data
    );
endinterface : iack_if

// ### hdl/iack_cpu.sv
// module: processor end, interrupt recognition and acknowledge cycle termination
// Summary of operation
// - take interrupt at boundary after higher exceptions
// - one handler instruction before next recognition
// - run acknowledge cycle to obtain vector
// - ack low, error and autovector high: latch vector
// - ack low, error high, autovector low: autovector
// - ack high, error low: spurious interrupt
// - ack and error both low: retry acknowledge
// - vectorless source requests autovector
// - external logic times out with error acknowledge
`timescale 1ns/100ps
module iack_cpu
    import iack_pkg::*;
(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    // link
    iack_if.cpu                           bus,
    // core side
    input  wire logic                     irq_pending,
    input  wire logic [iack_pkg::LVL_W-1:0] irq_level,
    input  wire logic                     insn_boundary,
    input  wire logic                     higher_exc_pending,
    output logic                          exc_take,
    output logic [iack_pkg::VEC_W-1:0]    exc_vector,
    output logic [1:0]                    exc_kind,
    output logic                          in_handler
);
    import iack_pkg::*;

    typedef struct packed {
        iack_cpu_state_t        st;
        logic [LVL_W-1:0]       lvl;
        logic [VEC_W-1:0]       vec;
        logic [1:0]             kind;
        logic                   take;
    } iack_cpu_reg_t;

    iack_cpu_reg_t cur_ff;
    iack_cpu_reg_t nxt_cur;

    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.take = 1'b0;
        case (cur_ff.st)
            IACK_CPU_IDLE: begin
                // higher priority exceptions go first
                if (irq_pending && insn_boundary && !higher_exc_pending) begin
                    nxt_cur.lvl = irq_level;
                    nxt_cur.st  = IACK_CPU_ACK;
                end
            end
            IACK_CPU_ACK: begin
                if (bus.transfer_acknowledge_n && bus.transfer_error_acknowledge_n) begin
                    nxt_cur.st = IACK_CPU_ACK;
                end else if (bus.transfer_acknowledge_n) begin
                    nxt_cur.vec  = VEC_SPURIOUS;
                    nxt_cur.kind = IACK_TERM_SPURIOUS;
                    nxt_cur.st   = IACK_CPU_DONE;
                end else if (bus.transfer_error_acknowledge_n) begin
                    if (bus.autovector_request_n) begin
                        nxt_cur.vec  = bus.data;
                        nxt_cur.kind = IACK_TERM_VECTOR;
                    end else begin
                        nxt_cur.vec  = VEC_AUTO_BASE + {5'h0_0, cur_ff.lvl};
                        nxt_cur.kind = IACK_TERM_AUTO;
                    end
                    nxt_cur.st = IACK_CPU_DONE;
                end else begin
                    // one idle cycle lets the source drop its strobes
                    nxt_cur.st = IACK_CPU_RETRY;
                end
            end
            IACK_CPU_RETRY: begin
                nxt_cur.st = IACK_CPU_ACK;
            end
            IACK_CPU_DONE: begin
                nxt_cur.take = 1'b1;
                nxt_cur.st   = IACK_CPU_HNDLR;
            end
            IACK_CPU_HNDLR: begin
                // first handler instruction must retire before re-arming
                if (insn_boundary) begin
                    nxt_cur.st = IACK_CPU_IDLE;
                end
            end
            default: begin
                nxt_cur.st = IACK_CPU_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign bus.iack_start = (cur_ff.st == IACK_CPU_IDLE) && (nxt_cur.st == IACK_CPU_ACK);
    assign bus.iack_busy  = (cur_ff.st == IACK_CPU_ACK);
    assign bus.iack_level = cur_ff.lvl;
    assign exc_take       = cur_ff.take;
    assign exc_vector     = cur_ff.vec;
    assign exc_kind       = cur_ff.kind;
    assign in_handler     = (cur_ff.st == IACK_CPU_HNDLR);
endmodule : iack_cpu

// ### hdl/iack_src.sv
// module: interrupt source end, answers acknowledge cycles and times out
`timescale 1ns/100ps
module iack_src
    import iack_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // link
    iack_if.src                        bus,
    // user side
    input  wire logic                  src_has_vector,
    input  wire logic [iack_pkg::VEC_W-1:0] src_vector,
    input  wire logic                  src_ready,
    input  wire logic                  src_retry,
    output logic                       src_served
);
    import iack_pkg::*;

    typedef struct packed {
        logic [TMO_W-1:0] tmo;
        logic             ack_n;
        logic             err_n;
        logic             auto_n;
        logic [VEC_W-1:0] dat;
        logic             served;
    } iack_src_reg_t;

    iack_src_reg_t cur_ff;
    iack_src_reg_t nxt_cur;

    always_comb begin
        nxt_cur        = cur_ff;
        nxt_cur.ack_n  = 1'b1;
        nxt_cur.err_n  = 1'b1;
        nxt_cur.auto_n = 1'b1;
        nxt_cur.served = 1'b0;
        // strobes last one cycle so a finished cycle is never seen twice
        if (bus.iack_busy && cur_ff.ack_n && cur_ff.err_n) begin
            if (src_ready && src_retry) begin
                nxt_cur.ack_n = 1'b0;
                nxt_cur.err_n = 1'b0;
            end else if (src_ready) begin
                nxt_cur.ack_n  = 1'b0;
                nxt_cur.auto_n = src_has_vector;
                nxt_cur.dat    = src_vector;
                nxt_cur.served = 1'b1;
            end else if (cur_ff.tmo == TMO_W'(TIMEOUT_CYC)) begin
                nxt_cur.err_n = 1'b0;
            end
            nxt_cur.tmo = cur_ff.tmo + TMO_W'(1);
        end else if (!bus.iack_busy) begin
            nxt_cur.tmo = '0;
        end
        if (nxt_cur.ack_n == 1'b0 || nxt_cur.err_n == 1'b0) begin
            nxt_cur.tmo = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cur_ff <= '{tmo: '0, ack_n: 1'b1, err_n: 1'b1, auto_n: 1'b1, dat: '0, served: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign bus.transfer_acknowledge_n       = cur_ff.ack_n;
    assign bus.transfer_error_acknowledge_n = cur_ff.err_n;
    assign bus.autovector_request_n         = cur_ff.auto_n;
    assign bus.data                         = cur_ff.dat;
    assign src_served                       = cur_ff.served;
endmodule : iack_src

// ### bench/iack_assertions.sv
// checker: protocol properties of the interrupt acknowledge link
`timescale 1ns/100ps
module iack_assertions (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       sys_rst,
    // link
    input wire logic       iack_start,
    input wire logic       iack_busy,
    input wire logic [2:0] iack_level,
    input wire logic       transfer_acknowledge_n,
    input wire logic       transfer_error_acknowledge_n,
    input wire logic       autovector_request_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_start_busy; iack_start |=> iack_busy; endproperty
    a_start_busy: assert property (p_start_busy) else $error("no busy after start");
    property p_level_hold; iack_busy && $past(iack_busy) |-> $stable(iack_level); endproperty
    a_level_hold: assert property (p_level_hold) else $error("level moved in cycle");
    property p_wait; iack_busy && transfer_acknowledge_n && transfer_error_acknowledge_n |=> iack_busy; endproperty
    a_wait: assert property (p_wait) else $error("cycle ended without strobe");
    property p_vector_end;
        iack_busy && !transfer_acknowledge_n && transfer_error_acknowledge_n && autovector_request_n |=> !iack_busy;
    endproperty
    a_vector_end: assert property (p_vector_end) else $error("vector end ignored");
    property p_auto_end;
        iack_busy && !transfer_acknowledge_n && transfer_error_acknowledge_n && !autovector_request_n |=> !iack_busy;
    endproperty
    a_auto_end: assert property (p_auto_end) else $error("autovector end ignored");
    property p_spurious_end; iack_busy && transfer_acknowledge_n && !transfer_error_acknowledge_n |=> !iack_busy; endproperty
    a_spurious_end: assert property (p_spurious_end) else $error("error end ignored");
    property p_retry;
        iack_busy && !transfer_acknowledge_n && !transfer_error_acknowledge_n |=> !iack_busy ##1 iack_busy;
    endproperty
    a_retry: assert property (p_retry) else $error("no retry cycle");
    // strobes outside a cycle would be misread as a later termination
    property p_strobe_in_cycle; !transfer_acknowledge_n || !transfer_error_acknowledge_n |-> iack_busy; endproperty
    a_strobe_in_cycle: assert property (p_strobe_in_cycle) else $error("strobe outside cycle");
endmodule : iack_assertions

// ### bench/tb_top.sv
// testbench: both ends joined, vector, autovector, spurious and retry cycles
`timescale 1ns/100ps
module tb_top;
    import iack_pkg::*;
    logic       core_clk, sys_rst, irq_pending, insn_boundary, higher_exc_pending;
    logic       src_has_vector, src_ready, src_retry, exc_take, in_handler, src_served;
    logic [2:0] irq_level;
    logic [7:0] src_vector, exc_vector;
    logic [1:0] exc_kind;
    logic [9:0] exp_q[$];
    int         miscompares, checked;
    logic       hang;
    iack_if bus ();
    iack_cpu i_iack_cpu (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .irq_pending(irq_pending),
        .irq_level(irq_level), .insn_boundary(insn_boundary), .higher_exc_pending(higher_exc_pending),
        .exc_take(exc_take), .exc_vector(exc_vector), .exc_kind(exc_kind), .in_handler(in_handler));
    iack_src i_iack_src (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .src_has_vector(src_has_vector),
        .src_vector(src_vector), .src_ready(src_ready), .src_retry(src_retry), .src_served(src_served));
    iack_assertions i_iack_assertions (.core_clk(core_clk), .sys_rst(sys_rst), .iack_start(bus.iack_start),
        .iack_busy(bus.iack_busy), .iack_level(bus.iack_level), .transfer_acknowledge_n(bus.transfer_acknowledge_n),
        .transfer_error_acknowledge_n(bus.transfer_error_acknowledge_n),
        .autovector_request_n(bus.autovector_request_n));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    // any take with no note pending is an unwanted recognition
    always @(negedge core_clk) begin
        if (exc_take === 1'b1) begin
            if (exp_q.size() == 0) chk({exc_kind, exc_vector}, 10'h3ff);
            else chk({exc_kind, exc_vector}, exp_q.pop_front());
        end
    end
    // mode 0 answer at once, 1 never answer, 2 retry first
    task automatic run_irq(input int mode, input logic has);
        logic [7:0] v;
        logic [2:0] l;
        int         n;
        v = 8'($urandom);
        l = 3'($urandom);
        @(negedge core_clk);
        {irq_pending, insn_boundary, higher_exc_pending, irq_level} = {3'b111, l};
        {src_has_vector, src_vector, src_ready, src_retry} = {has, v, mode != 1, mode == 2};
        if (mode == 1) exp_q.push_back({IACK_TERM_SPURIOUS, VEC_SPURIOUS});
        else if (has) exp_q.push_back({IACK_TERM_VECTOR, v});
        else exp_q.push_back({IACK_TERM_AUTO, VEC_AUTO_BASE + {5'h0, l}});
        repeat (3) @(negedge core_clk);
        higher_exc_pending = 1'b0;
        for (n = 0; n < 60 && in_handler !== 1'b1; n++) begin
            @(negedge core_clk);
            if (bus.iack_busy === 1'b1) insn_boundary = 1'b0;
            if (bus.transfer_acknowledge_n === 1'b0) begin
                chk(10'(src_served), 10'(!src_retry));
                src_retry = 1'b0;
            end
        end
        if (n == 60) begin
            miscompares++;
            hang = 1'b1;
            return;
        end
        // request held in handler must stay unrecognised
        repeat (3) begin
            @(negedge core_clk);
            chk({8'h0, in_handler, bus.iack_busy}, 10'h2);
        end
        {irq_pending, insn_boundary} = 2'b01;
        @(negedge core_clk);
        insn_boundary = 1'b0;
        chk(10'(in_handler), 10'h0);
    endtask : run_irq
    initial begin
        {irq_pending, insn_boundary, higher_exc_pending, irq_level} = 6'h0;
        {src_has_vector, src_vector, src_ready, src_retry} = 11'h0;
        miscompares = 0;
        checked = 0;
        hang = 1'b0;
        sys_rst = 1'b1;
        void'($urandom(62078));
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 6 && !hang; i++) run_irq(i % 3, i[1]);
        repeat (5) @(negedge core_clk);
        chk(10'(exp_q.size()), 10'h0);
        test_done();
    end
endmodule : tb_top
